// [core/sr4_pkg.sv]
//
// Purpose: shared constants and types of the four-stage shift register
// Assumes: one 100 MHz clock, all inputs from logic on that clock
// Notes:   stage one is bit 0, stage four is bit 3
//
package sr4_pkg;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int          SR4_STAGES    = 4;
    localparam int          SR4_BUF_DEPTH = 2;
    localparam logic [3:0]  SR4_STAGE_RST = 4'h0;
    localparam logic [1:0]  SR4_CNT_RST   = 2'h0;
    localparam logic [1:0]  SR4_CNT_FULL  = 2'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic {
        SR4_MODE_SERIAL   = 1'b0,
        SR4_MODE_PARALLEL = 1'b1
    } sr4_mode_t;

    typedef struct packed {
        logic       set_in;
        logic       clear_n;
        logic [3:0] par;
    } sr4_ctrl_t;

    typedef struct packed {
        logic       pol;
        logic [3:0] bits;
    } sr4_word_t;

    localparam int SR4_WORD_W = $bits(sr4_word_t);

endpackage

// [core/sr4_buf.sv]
//
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: same clock as the register
// Notes:   in_ready falls only when both entries hold words
//
`timescale 1ns/1ps
`default_nettype none
module sr4_buf
    import sr4_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire logic [SR4_WORD_W-1:0] in_data,
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output logic [SR4_WORD_W-1:0]      out_data
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [SR4_WORD_W-1:0] mem_r [SR4_BUF_DEPTH];
    logic [SR4_WORD_W-1:0] mem_nxt [SR4_BUF_DEPTH];
    logic                  wr_ptr_r;
    logic                  wr_ptr_nxt;
    logic                  rd_ptr_r;
    logic                  rd_ptr_nxt;
    logic [1:0]            cnt_r;
    logic [1:0]            cnt_nxt;
    logic                  push;
    logic                  pop;
    logic                  in_ready_r;
    logic                  in_ready_nxt;
    logic                  out_valid_r;
    logic                  out_valid_nxt;
    logic [SR4_WORD_W-1:0] out_data_r;
    logic [SR4_WORD_W-1:0] out_data_nxt;

    // flags and head word are registered so the ports come straight from flops
    assign in_ready  = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;
    assign push      = in_valid && in_ready_r;
    assign pop       = out_valid_r && out_ready;

    always_comb begin
        mem_nxt    = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt    = cnt_r;
        if (push) begin
            mem_nxt[wr_ptr_r] = in_data;
            wr_ptr_nxt        = ~wr_ptr_r;
        end
        if (pop) begin
            rd_ptr_nxt = ~rd_ptr_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
        in_ready_nxt  = (cnt_nxt != SR4_CNT_FULL);
        out_valid_nxt = (cnt_nxt != SR4_CNT_RST);
        out_data_nxt  = mem_nxt[rd_ptr_nxt];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r       <= SR4_CNT_RST;
            in_ready_r  <= 1'b1;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else begin
            mem_r       <= mem_nxt;
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            cnt_r       <= cnt_nxt;
            in_ready_r  <= in_ready_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r  <= out_data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_buf_bound;
        @(posedge clk) disable iff (rst)
        cnt_r <= SR4_CNT_FULL;
    endproperty
    a_buf_bound: assert property (p_buf_bound) else $error("buffer count above two");

    property p_buf_stall;
        @(posedge clk) disable iff (rst)
        (cnt_r == SR4_CNT_FULL) && !out_ready |=> !in_ready;
    endproperty
    a_buf_stall: assert property (p_buf_stall) else $error("full buffer took a word");

endmodule
`default_nettype wire

// [core/sr4_core.sv]
//
// Purpose: four-stage shift register with parallel load and set/clear front end
// Assumes: inputs come from logic on REF_CLK, so none is synchronised
// Notes:   a step happens on an edge where STEP_VALID and STEP_READY are high;
//          each step also pushes the new contents into a two-entry buffer
`timescale 1ns/1ps
`default_nettype none
module sr4_core
    import sr4_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       STEP_VALID,
    output logic            STEP_READY,
    input  wire logic       LOAD_SEL,
    input  wire logic       SET_IN,
    input  wire logic       CLEAR_N,
    input  wire logic [3:0] PAR_IN,
    input  wire logic       POL_SEL,
    output logic [3:0]      Q_OUT,
    output logic            WORD_VALID,
    input  wire logic       WORD_READY,
    output logic [3:0]      WORD_BITS,
    output logic            WORD_POL
);

    // ----------------------------------------------------------------
    // stage storage
    // ----------------------------------------------------------------
    sr4_ctrl_t   ctrl;
    sr4_mode_t   mode;
    logic [3:0]  stage_r;
    logic [3:0]  stage_nxt;
    logic [3:0]  shift_nxt;
    logic        step;
    logic        buf_ready;
    sr4_word_t   push_word;
    sr4_word_t   pop_word;

    assign ctrl  = '{set_in: SET_IN, clear_n: CLEAR_N, par: PAR_IN};
    assign mode  = sr4_mode_t'(LOAD_SEL);
    assign step  = STEP_VALID && buf_ready;

    // first stage behaves as a JK flip-flop with K taken active low
    assign shift_nxt[0] = (ctrl.set_in & ~stage_r[0])
                        | (ctrl.clear_n & stage_r[0]);

    genvar gi;
    generate
        for (gi = 1; gi < SR4_STAGES; gi++) begin : g_chain
            assign shift_nxt[gi] = stage_r[gi-1];
        end
    endgenerate

    always_comb begin
        stage_nxt = stage_r;
        if (step) begin
            case (mode)
                SR4_MODE_PARALLEL: begin
                    stage_nxt = ctrl.par;
                end
                SR4_MODE_SERIAL: begin
                    stage_nxt = shift_nxt;
                end
                default: begin
                    stage_nxt = stage_r;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            stage_r <= SR4_STAGE_RST;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // polarity is a pure gate on the stored bits, so no edge is waited for
    assign Q_OUT = POL_SEL ? stage_r : ~stage_r;

    // ----------------------------------------------------------------
    // word buffer
    // ----------------------------------------------------------------
    assign push_word = '{pol: POL_SEL, bits: stage_nxt};

    sr4_buf u_buf (
        .clk       (REF_CLK),
        .rst       (RST),
        .in_valid  (STEP_VALID),
        .in_ready  (buf_ready),
        .in_data   (push_word),
        .out_valid (WORD_VALID),
        .out_ready (WORD_READY),
        .out_data  (pop_word)
    );

    assign STEP_READY = buf_ready;
    assign WORD_BITS  = pop_word.bits;
    assign WORD_POL   = pop_word.pol;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    property p_par_load;
        step && LOAD_SEL |=> stage_r == $past(PAR_IN);
    endproperty
    a_par_load: assert property (p_par_load) else $error("parallel load missed");

    property p_shift;
        step && !LOAD_SEL |=> stage_r[3:1] == $past(stage_r[2:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("serial shift wrong");

    property p_jk_clear;
        step && !LOAD_SEL && !SET_IN && !CLEAR_N |=> !stage_r[0];
    endproperty
    a_jk_clear: assert property (p_jk_clear) else $error("first stage not cleared");

    property p_jk_set;
        step && !LOAD_SEL && SET_IN && CLEAR_N |=> stage_r[0];
    endproperty
    a_jk_set: assert property (p_jk_set) else $error("first stage not set");

    property p_jk_hold;
        step && !LOAD_SEL && !SET_IN && CLEAR_N |=> $stable(stage_r[0]);
    endproperty
    a_jk_hold: assert property (p_jk_hold) else $error("first stage did not hold");

    property p_jk_toggle;
        step && !LOAD_SEL && SET_IN && !CLEAR_N |=> stage_r[0] != $past(stage_r[0]);
    endproperty
    a_jk_toggle: assert property (p_jk_toggle) else $error("first stage held");

    property p_d_mode;
        step && !LOAD_SEL && (SET_IN == CLEAR_N) |=> stage_r[0] == $past(SET_IN);
    endproperty
    a_d_mode: assert property (p_d_mode) else $error("tied inputs not a D stage");

    // ----------------------------------------------------------------
    // output, idle and reset checks
    // ----------------------------------------------------------------
    property p_true_out;
        POL_SEL |-> Q_OUT == stage_r;
    endproperty
    a_true_out: assert property (p_true_out) else $error("true output wrong");

    property p_comp_out;
        !POL_SEL |-> Q_OUT == ~stage_r;
    endproperty
    a_comp_out: assert property (p_comp_out) else $error("complement output wrong");

    property p_idle_stable;
        !step |=> $stable(stage_r);
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("moved without step");

    property p_reset_zero;
        @(posedge REF_CLK) disable iff (1'b0)
        RST |-> stage_r == SR4_STAGE_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("stage not cleared");

    property p_reset_buf;
        @(posedge REF_CLK) disable iff (1'b0)
        RST |-> STEP_READY && !WORD_VALID;
    endproperty
    a_reset_buf: assert property (p_reset_buf) else $error("buffer not cleared");

    // ----------------------------------------------------------------
    // storage and word stream checks
    // ----------------------------------------------------------------
    property p_ser_next;
        step && !LOAD_SEL |=> stage_r == $past(shift_nxt);
    endproperty
    a_ser_next: assert property (p_ser_next) else $error("parallel data leaked");

    property p_pol_keep;
        $changed(POL_SEL) && !step |=> $stable(stage_r);
    endproperty
    a_pol_keep: assert property (p_pol_keep) else $error("stage moved on polarity");

    property p_refused;
        STEP_VALID && !STEP_READY |=> $stable(stage_r);
    endproperty
    a_refused: assert property (p_refused) else $error("refused step moved stage");

    property p_word_head;
        step && !WORD_VALID |=> WORD_BITS == stage_r && WORD_POL == $past(POL_SEL);
    endproperty
    a_word_head: assert property (p_word_head) else $error("pushed word not at head");

    property p_word_hold;
        WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_BITS) && $stable(WORD_POL);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("held word changed");

    // ----------------------------------------------------------------
    // covers
    // ----------------------------------------------------------------
    c_par_load: cover property (step && LOAD_SEL);
    c_toggle:   cover property (step && !LOAD_SEL && SET_IN && !CLEAR_N);
    c_stall:    cover property (STEP_VALID && !STEP_READY);
    c_pol_flip: cover property (POL_SEL ##1 !POL_SEL);
    c_d_mode:   cover property (step && !LOAD_SEL && (SET_IN == CLEAR_N));

endmodule
`default_nettype wire

// [verif/sr4_sink.sv]
// Purpose: consumer model for the word stream of the shift register
// Assumes: runs on REF_CLK, stall driven by the bench
// Notes:   ready is the inverse of stall; each popped word is captured
`timescale 1ns/1ps
`default_nettype none
module sr4_sink
    import sr4_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  stall,
    input  wire logic                  wvalid,
    input  wire logic [SR4_WORD_W-1:0] wdata,
    output logic                       wready,
    output logic                       got,
    output logic [SR4_WORD_W-1:0]      got_w
);
    // a stall holds ready low for as long as the bench asks
    assign wready = ~stall;
    always_ff @(posedge clk) begin
        got   <= wvalid & wready;
        got_w <= wdata;
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Purpose: self-checking bench of the four-stage shift register
// Assumes: 100 MHz REF_CLK, inputs driven on rising edges
// Notes:   row = {sel,set,clear_n,pol, par, expected Q_OUT}
`timescale 1ns/1ps
`default_nettype none
module tb
    import sr4_pkg::*;
;
    logic       REF_CLK = 1'b0, RST = 1'b0, STEP_VALID = 1'b0, LOAD_SEL = 1'b0;
    logic       SET_IN = 1'b0, CLEAR_N = 1'b0, POL_SEL = 1'b0, stall = 1'b0;
    logic [3:0] PAR_IN = 4'h0, st = 4'h0;
    wire logic       STEP_READY, WORD_VALID, WORD_READY, WORD_POL, got;
    wire logic [3:0] Q_OUT, WORD_BITS;
    wire logic [4:0] got_w;
    logic [4:0] expq[$];
    int         n_errors = 0, n_compared = 0, cycles = 0;
    logic [11:0] rows[8] = '{12'h955, 12'h7FB, 12'h039, 12'h30C,
                             12'h4F6, 12'h502, 12'h8A5, 12'h1F4};

    sr4_core sr4_core_i (.REF_CLK(REF_CLK), .RST(RST), .STEP_VALID(STEP_VALID),
        .STEP_READY(STEP_READY), .LOAD_SEL(LOAD_SEL), .SET_IN(SET_IN), .CLEAR_N(CLEAR_N),
        .PAR_IN(PAR_IN), .POL_SEL(POL_SEL), .Q_OUT(Q_OUT), .WORD_VALID(WORD_VALID),
        .WORD_READY(WORD_READY), .WORD_BITS(WORD_BITS), .WORD_POL(WORD_POL));
    sr4_sink sr4_sink_i (.clk(REF_CLK), .stall(stall), .wvalid(WORD_VALID),
        .wdata({WORD_POL, WORD_BITS}), .wready(WORD_READY), .got(got), .got_w(got_w));

    always #5 REF_CLK = ~REF_CLK;

    // ----------------------------------------------------------------
    // compare and report
    // ----------------------------------------------------------------
    task automatic fail(input logic [4:0] g, input logic [4:0] e);
        n_errors++;
        $display("mismatch t=%0t got %h exp %h", $time, g, e);
    endtask
    task automatic chk_f(input logic g, input logic e);
        n_compared++;
        if (g !== e) fail({4'h0, g}, {4'h0, e});
    endtask
    task automatic chk_q(input logic [3:0] g, input logic [3:0] e);
        n_compared++;
        if (g !== e) fail({1'b0, g}, {1'b0, e});
    endtask
    task automatic chk_w(input logic [4:0] g, input logic [4:0] e);
        n_compared++;
        if (g !== e) fail(g, e);
    endtask
    task automatic report_and_stop;
        $display("counts: compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // an idle edge, then one taken step per call
    task automatic step(input logic [11:0] r);
        @(posedge REF_CLK);
        {LOAD_SEL, SET_IN, CLEAR_N, POL_SEL} <= r[11:8];
        PAR_IN     <= r[7:4];
        STEP_VALID <= 1'b1;
        @(posedge REF_CLK);
        STEP_VALID <= 1'b0;
        st = r[8] ? r[3:0] : ~r[3:0];
        expq.push_back({r[8], st});
        #1 chk_q(Q_OUT, r[3:0]);
    endtask

    always @(posedge REF_CLK) begin
        if (got === 1'b1)
            chk_w(got_w, expq.pop_front());
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        RST <= 1'b1;
        repeat (10) @(posedge REF_CLK);
        chk_q(Q_OUT, 4'hF);
        RST     <= 1'b0;
        POL_SEL <= 1'b1;
        #1 chk_q(Q_OUT, 4'h0);
        chk_f(STEP_READY, 1'b1);
        chk_f(WORD_VALID, 1'b0);
        $display("test reset done");
        foreach (rows[i]) step(rows[i]);
        $display("test rows done");
        @(posedge REF_CLK);
        {LOAD_SEL, PAR_IN} <= 5'h1B;
        POL_SEL <= 1'b0;
        #1 chk_q(Q_OUT, ~st);
        repeat (2) @(posedge REF_CLK);
        POL_SEL <= 1'b1;
        #1 chk_q(Q_OUT, st);
        $display("test polarity done");
        @(posedge REF_CLK);
        stall <= 1'b1;
        {LOAD_SEL, SET_IN, CLEAR_N} <= 3'b011;
        STEP_VALID <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        STEP_VALID <= 1'b0;
        repeat (2) begin
            st = {st[2:0], 1'b1};
            expq.push_back({1'b1, st});
        end
        #1 chk_q(Q_OUT, st);
        chk_f(STEP_READY, 1'b0);
        chk_f(WORD_VALID, 1'b1);
        @(posedge REF_CLK);
        stall <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        #1 chk_f(WORD_VALID, 1'b0);
        chk_f(expq.size() == 0, 1'b1);
        $display("test stall done");
        @(posedge REF_CLK);
        stall <= 1'b1;
        step(rows[6]);
        chk_f(WORD_VALID, 1'b1);
        @(posedge REF_CLK);
        RST <= 1'b1;
        #1 chk_q(Q_OUT, 4'hF);
        chk_f(WORD_VALID, 1'b0);
        chk_f(STEP_READY, 1'b1);
        expq.delete();
        @(posedge REF_CLK);
        RST   <= 1'b0;
        stall <= 1'b0;
        step(rows[0]);
        repeat (3) @(posedge REF_CLK);
        chk_f(expq.size() == 0, 1'b1);
        $display("test midreset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
